// File: dv/ext_osc_model.sv
// behavioural external oscillator that can be stopped to fake a failure
`timescale 1ns/1ps
`default_nettype none
module ext_osc_model #(
    parameter int HALF_NS = 125
) (
    input wire logic run_i,
    output logic osc_o
);
    // a stopped source parks high, so no low level can hide the failure
    initial osc_o = 1'b0;
    always
    begin
        #(HALF_NS);
        if (run_i)
            osc_o = ~osc_o;
        else
            osc_o = 1'b1;
    end
endmodule : ext_osc_model
`default_nettype wire

// File: dv/fail_monitor_chk.sv
// port assertions for the fail-safe clock monitor
`timescale 1ns/1ps
`default_nettype none
module fail_monitor_chk
    import fail_monitor_pkg::*;
#(
    parameter int SETTLE_CYCLES = SETTLE_COUNT,
    parameter int LF_DIV = SAMPLE_DIV
) (
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic [1:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic monitor_enable_fuse_i,
    input wire logic [2:0] primary_osc_config_i,
    input wire logic sleep_i,
    input wire logic wake_i,
    input wire logic [1:0] clk_src_o,
    input wire logic [3:0] internal_freq_select_o,
    input wire logic osc_fail_irq_o
);
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!nrst_i);
    // ----------
    // helpers
    // ----------
    // quiet cycles since software, sleep, wake or a fuse last touched the source
    logic [2:0] calm_q;
    logic ctl_wr;
    assign ctl_wr = reg_wr_i && reg_addr_i == ADDR_OSC_CONTROL;
    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            calm_q <= 3'h0;
        else if (reg_wr_i || sleep_i || wake_i || !$stable(primary_osc_config_i)
                 || !$stable(monitor_enable_fuse_i))
            calm_q <= 3'h0;
        else if (calm_q != 3'h7)
            calm_q <= calm_q + 3'h1;
    end
    // ----------
    // assertions
    // ----------
    reset_values_a: assert property (
        $rose(nrst_i) |-> internal_freq_select_o == IFS_RESET && clk_src_o == 2'h0
        && !osc_fail_irq_o) else $error("wrong values after reset");
    freq_write_a: assert property (
        ctl_wr |=> ##1 internal_freq_select_o == $past(reg_wdata_i[IFS_MSB:IFS_LSB], 2))
        else $error("frequency select not taken from write");
    freq_hold_a: assert property (
        !ctl_wr && !$past(ctl_wr) |=> $stable(internal_freq_select_o))
        else $error("frequency select moved without a write");
    ctrl_pad_a: assert property (
        reg_rd_i && reg_addr_i == ADDR_OSC_CONTROL |=> !reg_rdata_o[7] && !reg_rdata_o[2])
        else $error("unused control bits read as one");
    ctrl_freq_a: assert property (
        reg_rd_i && reg_addr_i == ADDR_OSC_CONTROL
        |=> reg_rdata_o[6:3] == internal_freq_select_o)
        else $error("frequency field read back wrong");
    fuse_off_a: assert property (
        !monitor_enable_fuse_i && calm_q == 3'h7 && clk_src_o == SRC_EXTERNAL
        |=> clk_src_o == SRC_EXTERNAL) else $error("source left external with monitor off");
    src_code_a: assert property (
        clk_src_o != 2'h3) else $error("undefined clock source code");
    irq_drop_a: assert property (
        $fell(osc_fail_irq_o) |-> $past(reg_wr_i) || $past(reg_wr_i, 2) || $past(reg_wr_i, 3))
        else $error("interrupt dropped without a write");
endmodule : fail_monitor_chk

bind fail_safe_clock_monitor fail_monitor_chk #(
    .SETTLE_CYCLES(SETTLE_CYCLES),
    .LF_DIV(LF_DIV)
) i_fail_monitor_chk (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o),
    .monitor_enable_fuse_i(monitor_enable_fuse_i),
    .primary_osc_config_i(primary_osc_config_i),
    .sleep_i(sleep_i),
    .wake_i(wake_i),
    .clk_src_o(clk_src_o),
    .internal_freq_select_o(internal_freq_select_o),
    .osc_fail_irq_o(osc_fail_irq_o)
);
`default_nettype wire

// File: dv/fail_safe_clock_monitor_tb.sv
// self-checking bench for the fail-safe clock monitor
`timescale 1ns/1ps
`default_nettype none
module fail_safe_clock_monitor_tb
    import fail_monitor_pkg::*;
;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [1:0] addr = 2'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic fuse = 1'b1;
    logic [2:0] cfg = CFG_XT;
    logic slp = 1'b0;
    logic wk = 1'b0;
    logic run = 1'b1;
    logic lf = 1'b0;
    logic ext;
    logic irq;
    logic [7:0] rdata;
    logic [7:0] rv;
    logic [7:0] ctl;
    logic [1:0] src;
    logic [3:0] fsel;
    logic [31:0] rs = 32'h5622;
    logic [2:0] modes [5] = '{CFG_LP, CFG_XT, CFG_HS, CFG_EXT_RC, CFG_EXT_CLK};
    int mismatches = 0;
    int samples_checked = 0;

    // system clock and a slow oscillator of unrelated phase
    always #12.5 clk = ~clk;
    always #200 lf = ~lf;

    ext_osc_model #(.HALF_NS(125)) i_ext_osc_model (.run_i(run), .osc_o(ext));
    // short counts keep the run brief
    fail_safe_clock_monitor #(.SETTLE_CYCLES(8), .LF_DIV(8)) i_fail_safe_clock_monitor (
        .sys_clk_i(clk),
        .nrst_i(nrst),
        .reg_addr_i(addr),
        .reg_wdata_i(wdata),
        .reg_wr_i(wr),
        .reg_rd_i(rd),
        .reg_rdata_o(rdata),
        .monitor_enable_fuse_i(fuse),
        .two_speed_fuse_i(1'b1),
        .primary_osc_config_i(cfg),
        .sleep_i(slp),
        .wake_i(wk),
        .ext_osc_i(ext),
        .low_freq_internal_osc_i(lf),
        .clk_src_o(src),
        .internal_freq_select_o(fsel),
        .osc_fail_irq_o(irq)
    );

    function automatic logic [31:0] xs();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs;
    endfunction : xs

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    // read data stand only in the cycle after the strobe
    task automatic rd_chk(input logic [1:0] a, input logic [7:0] exp, input string what);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        rv = rdata;
        chk(what, exp, rv);
    endtask : rd_chk

    task automatic pls(input bit wake);
        @(posedge clk);
        wk <= wake;
        slp <= !wake;
        @(posedge clk);
        wk <= 1'b0;
        slp <= 1'b0;
    endtask : pls

    task automatic irq_is(input logic v);
        repeat (2) @(posedge clk);
        #1;
        chk("irq", {7'h0, v}, {7'h0, irq});
    endtask : irq_is

    // bounded wait for the interrupt or for a clock source
    task automatic wt(input bit on_irq, input logic [1:0] v);
        int n = 0;
        while ((on_irq ? irq !== 1'b1 : src !== v) && n < 2000)
        begin
            @(posedge clk);
            n++;
        end
        #1;
        if (on_irq)
            chk("irq", 8'h01, {7'h0, irq});
        else
            chk("source", {6'h0, v}, {6'h0, src});
    endtask : wt

    task automatic print_verdict();
        if (mismatches == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : print_verdict

    // watchdog: the tests need well under a quarter of this
    initial
    begin
        #400000;
        mismatches++;
        print_verdict();
    end

    initial
    begin
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        rd_chk(ADDR_OSC_CONTROL, 8'h38, "control");
        chk("source", 8'h00, {6'h0, src});
        rd_chk(ADDR_OSC_STATUS, 8'h00, "status");
        // random control writes against the model
        repeat (6)
        begin
            ctl = 8'(xs());
            wr_reg(ADDR_OSC_CONTROL, ctl);
            ctl = ctl & 8'h7b;
            rd_chk(ADDR_OSC_CONTROL, ctl, "control");
            chk("freq", {4'h0, ctl[6:3]}, {4'h0, fsel});
        end
        wr_reg(ADDR_OSC_CONTROL, 8'h38);
        // interrupt raised, masked and cleared by software
        wr_reg(ADDR_INT_EN_TWO, 8'hff);
        rd_chk(ADDR_INT_EN_TWO, 8'h80, "enable");
        wr_reg(ADDR_FLAGS_TWO, 8'h80);
        irq_is(1'b1);
        wr_reg(ADDR_INT_EN_TWO, 8'h00);
        irq_is(1'b0);
        wr_reg(ADDR_FLAGS_TWO, 8'h00);
        wr_reg(ADDR_INT_EN_TWO, 8'h80);
        irq_is(1'b0);
        // first failure from a running crystal
        wt(1'b0, SRC_EXTERNAL);
        run = 1'b0;
        wt(1'b0, SRC_INTERNAL);
        // each external mode settles, runs external, then fails
        foreach (modes[i])
        begin
            cfg <= modes[i];
            run = 1'b1;
            wr_reg(ADDR_FLAGS_TWO, 8'h00);
            pls(1'b1);
            wt(1'b0, SRC_EXTERNAL);
            rd_chk(ADDR_OSC_STATUS, 8'h20, "status");
            run = 1'b0;
            wt(1'b0, SRC_INTERNAL);
            rd_chk(ADDR_OSC_STATUS, 8'h01, "status");
            rd_chk(ADDR_FLAGS_TWO, 8'h80, "flag");
            irq_is(1'b1);
        end
        // switching back while the source is still dead
        // clear flag first
        wr_reg(ADDR_FLAGS_TWO, 8'h00);
        wr_reg(ADDR_OSC_CONTROL, 8'h3a);
        wr_reg(ADDR_OSC_CONTROL, 8'h38);
        wt(1'b1, SRC_INTERNAL);
        rd_chk(ADDR_FLAGS_TWO, 8'h80, "flag");
        run = 1'b1;
        repeat (300) @(posedge clk);
        #1;
        chk("source", 8'h00, {6'h0, src});
        rd_chk(ADDR_OSC_CONTROL, 8'h38, "control");
        pls(1'b0);
        rd_chk(ADDR_OSC_STATUS, 8'h20, "failure");
        // monitor fuse off: a dead crystal goes unnoticed
        run = 1'b0;
        fuse <= 1'b0;
        cfg <= CFG_XT;
        pls(1'b1);
        wt(1'b0, SRC_INTERNAL);
        wr_reg(ADDR_FLAGS_TWO, 8'h00);
        run = 1'b1;
        wt(1'b0, SRC_EXTERNAL);
        run = 1'b0;
        repeat (400) @(posedge clk);
        #1;
        chk("source", 8'h01, {6'h0, src});
        rd_chk(ADDR_FLAGS_TWO, 8'h00, "flag");
        print_verdict();
    end
endmodule : fail_safe_clock_monitor_tb
`default_nettype wire

// File: logic/edge_counter.sv
// counts qualified events and pulses when a terminal count is reached
`timescale 1ns/1ps
`default_nettype none
module edge_counter #(
    parameter int COUNT = 64
) (
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic restart_i,
    input wire logic event_i,
    output logic done_o
);
    localparam int W = $clog2(COUNT);
    logic [W-1:0] cnt_q;

    initial
    begin
        if (COUNT < 2)
            $error("edge_counter: COUNT must be at least 2");
    end

    // wraps after COUNT events; done pulses on the last one
    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            cnt_q <= '0;
        end
        else if (restart_i)
        begin
            cnt_q <= '0;
        end
        else if (event_i)
        begin
            cnt_q <= (cnt_q == W'(COUNT - 1)) ? '0 : cnt_q + 1'b1;
        end
    end

    assign done_o = event_i && !restart_i && (cnt_q == W'(COUNT - 1));
endmodule : edge_counter
`default_nettype wire

// File: logic/fail_monitor_pkg.sv
// constants for the fail-safe clock monitor and oscillator control block
package fail_monitor_pkg;
    // register map (offsets chosen here, one byte register each)
    localparam logic [1:0] ADDR_OSC_CONTROL = 2'h0;
    localparam logic [1:0] ADDR_OSC_STATUS = 2'h1;
    localparam logic [1:0] ADDR_FLAGS_TWO = 2'h2;
    localparam logic [1:0] ADDR_INT_EN_TWO = 2'h3;
    // oscillator control field layout
    localparam int IFS_LSB = 3;
    localparam int IFS_MSB = 6;
    localparam int SCS_LSB = 0;
    localparam int SCS_MSB = 1;
    localparam logic [3:0] IFS_RESET = 4'h7;
    localparam logic [1:0] SCS_RESET = 2'h0;
    localparam logic [1:0] SCS_CONFIG = 2'h0;
    localparam logic [1:0] SCS_SECONDARY = 2'h1;
    // status and flag bit positions
    localparam int EXT_CLOCK_RUNNING_FLAG_BIT = 5;
    localparam int FAIL_STATE_BIT = 0;
    localparam int OSC_FAIL_FLAG_BIT = 7;
    localparam int OSC_FAIL_IE_BIT = 7;
    // primary oscillator configuration codes
    localparam logic [2:0] CFG_LP = 3'h0;
    localparam logic [2:0] CFG_XT = 3'h1;
    localparam logic [2:0] CFG_HS = 3'h2;
    localparam logic [2:0] CFG_EXT_RC = 3'h3;
    localparam logic [2:0] CFG_INTERNAL_OSC_BLOCK = 3'h4;
    localparam logic [2:0] CFG_EXT_CLK = 3'h7;
    // timing: sample clock divides low-frequency osc by 64, settle timer 1024 cycles
    localparam int SAMPLE_DIV = 64;
    localparam int SETTLE_COUNT = 1024;
    // clock source selection seen by the clock mux
    typedef enum logic [1:0] {
        SRC_INTERNAL = 2'b00,
        SRC_EXTERNAL = 2'b01,
        SRC_SECONDARY = 2'b10
    } clk_src_t;
    typedef enum logic [1:0] {
        ST_SETTLE = 2'b00,
        ST_EXTERNAL = 2'b01,
        ST_FAILED = 2'b10,
        ST_INTERNAL = 2'b11
    } mon_state_t;
endpackage : fail_monitor_pkg

// File: logic/fail_safe_clock_monitor.sv
// fail-safe clock monitor with oscillator control register and settle timer
//
// The address-and-strobe port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module fail_safe_clock_monitor
    import fail_monitor_pkg::*;
#(
    parameter int SETTLE_CYCLES = SETTLE_COUNT,
    parameter int LF_DIV = SAMPLE_DIV
) (
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    // register port
    input wire logic [1:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    // configuration words
    input wire logic monitor_enable_fuse_i,
    input wire logic two_speed_fuse_i,
    input wire logic [2:0] primary_osc_config_i,
    // sleep instruction executed and wake-up completed, one-cycle pulses
    input wire logic sleep_i,
    input wire logic wake_i,
    // oscillator pins (asynchronous)
    input wire logic ext_osc_i,
    input wire logic low_freq_internal_osc_i,
    // clock mux control and oscillator-fail interrupt
    output logic [1:0] clk_src_o,
    output logic [3:0] internal_freq_select_o,
    output logic osc_fail_irq_o
);
    initial
    begin
        if (SETTLE_CYCLES < 2 || LF_DIV < 4 || (LF_DIV % 2) != 0)
            $error("fail_safe_clock_monitor: unsupported parameter values");
    end

    // ------------------------------------------------------------
    // pin synchronisers and edge detection
    // ------------------------------------------------------------
    logic ext_s;
    logic lf_s;
    logic ext_prev_q;
    logic lf_prev_q;
    logic ext_fall;
    logic ext_rise;
    logic lf_rise;

    level_sync u_sync_ext (
        .sys_clk_i(sys_clk_i),
        .nrst_i(nrst_i),
        .async_i(ext_osc_i),
        .sync_o(ext_s)
    );

    level_sync u_sync_lf (
        .sys_clk_i(sys_clk_i),
        .nrst_i(nrst_i),
        .async_i(low_freq_internal_osc_i),
        .sync_o(lf_s)
    );

    // edge history taken only from the synchronised levels
    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            ext_prev_q <= 1'b0;
            lf_prev_q <= 1'b0;
        end
        else
        begin
            ext_prev_q <= ext_s;
            lf_prev_q <= lf_s;
        end
    end

    assign ext_fall = ext_prev_q && !ext_s;
    assign ext_rise = !ext_prev_q && ext_s;
    assign lf_rise = !lf_prev_q && lf_s;

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    logic [3:0] ifs_q;
    logic [1:0] scs_q;
    logic osc_fail_flag_q;
    logic osc_fail_ie_q;
    logic scs_change;
    logic wr_ctrl;
    logic wr_flags;
    logic wr_ie;

    assign wr_ctrl = reg_wr_i && (reg_addr_i == ADDR_OSC_CONTROL);
    assign wr_flags = reg_wr_i && (reg_addr_i == ADDR_FLAGS_TWO);
    assign wr_ie = reg_wr_i && (reg_addr_i == ADDR_INT_EN_TWO);
    assign scs_change = wr_ctrl && (reg_wdata_i[SCS_MSB:SCS_LSB] != scs_q);

    // only software writes touch the select bits
    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            ifs_q <= IFS_RESET;
            scs_q <= SCS_RESET;
        end
        else if (wr_ctrl)
        begin
            ifs_q <= reg_wdata_i[IFS_MSB:IFS_LSB];
            scs_q <= reg_wdata_i[SCS_MSB:SCS_LSB];
        end
    end

    // interrupt enable in the second enable register
    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            osc_fail_ie_q <= 1'b0;
        else if (wr_ie)
            osc_fail_ie_q <= reg_wdata_i[OSC_FAIL_IE_BIT];
    end

    // ------------------------------------------------------------
    // sample clock and detector latch
    // ------------------------------------------------------------
    logic half_tick;
    logic sample_q;
    logic sample_rise;
    logic latch_q;
    logic fail_detect;
    logic monitor_on;

    // half-period tick every LF_DIV/2 low-frequency edges
    edge_counter #(
        .COUNT(LF_DIV / 2)
    ) u_sample_div (
        .sys_clk_i(sys_clk_i),
        .nrst_i(nrst_i),
        .restart_i(1'b0),
        .event_i(lf_rise),
        .done_o(half_tick)
    );

    // sample clock toggles every half period
    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            sample_q <= 1'b0;
        else if (half_tick)
            sample_q <= !sample_q;
    end

    assign sample_rise = half_tick && !sample_q;

    // latch set by ext fall, cleared by sample rise
    // set wins so a fall on the clearing edge is not lost
    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            latch_q <= 1'b0;
        else if (ext_fall)
            latch_q <= 1'b1;
        else if (sample_rise)
            latch_q <= 1'b0;
    end

    // latch still clear at the falling sample edge: a whole half-cycle went by
    assign fail_detect = half_tick && sample_q && !latch_q && !ext_fall;

    // ------------------------------------------------------------
    // settle timer and source state machine
    // ------------------------------------------------------------
    mon_state_t state_q;
    logic settle_restart;
    logic settle_done;
    logic crystal_mode;
    logic needs_settle;
    logic two_speed;
    logic primary_external;

    // every external mode is watched; internal config is not
    assign primary_external = (primary_osc_config_i != CFG_INTERNAL_OSC_BLOCK);
    assign crystal_mode = (primary_osc_config_i == CFG_LP) || (primary_osc_config_i == CFG_XT)
                          || (primary_osc_config_i == CFG_HS);
    // ext clock and rc skip the settle timer
    assign needs_settle = crystal_mode;
    assign two_speed = two_speed_fuse_i || monitor_enable_fuse_i;
    assign monitor_on = monitor_enable_fuse_i && primary_external;

    // select change or wake restarts settle timer
    assign settle_restart = scs_change || wake_i || sleep_i || (state_q != ST_SETTLE);

    // counts external oscillator cycles
    edge_counter #(
        .COUNT(SETTLE_CYCLES)
    ) u_settle (
        .sys_clk_i(sys_clk_i),
        .nrst_i(nrst_i),
        .restart_i(settle_restart),
        .event_i(ext_rise),
        .done_o(settle_done)
    );

    // reset, sleep and select changes clear the failure
    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            state_q <= ST_SETTLE;
        end
        else if (sleep_i || wake_i || scs_change)
        begin
            state_q <= ST_SETTLE;
        end
        else
        begin
            unique case (state_q)
                ST_SETTLE:
                begin
                    if (!primary_external)
                        state_q <= ST_INTERNAL;
                    else if (!needs_settle || settle_done)
                        state_q <= ST_EXTERNAL;
                end
                ST_EXTERNAL:
                begin
                    if (monitor_on && fail_detect)
                        state_q <= ST_FAILED;
                end
                ST_FAILED:
                begin
                    // hold internal until a select change, sleep or wake
                    state_q <= ST_FAILED;
                end
                ST_INTERNAL:
                begin
                    if (primary_external)
                        state_q <= ST_SETTLE;
                end
            endcase
        end
    end

    // set on failure or by a software write of one; a failed source sets it again only after a restart and a new failure
    // software clears with a write of zero; a new failure wins
    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            osc_fail_flag_q <= 1'b0;
        else if (state_q == ST_EXTERNAL && monitor_on && fail_detect)
            osc_fail_flag_q <= 1'b1;
        else if (wr_flags)
            osc_fail_flag_q <= reg_wdata_i[OSC_FAIL_FLAG_BIT];
    end

    // ------------------------------------------------------------
    // clock source selection
    // ------------------------------------------------------------
    logic ext_running;
    logic [1:0] src_d;

    assign ext_running = (state_q == ST_EXTERNAL) && (scs_q == SCS_CONFIG);

    always_comb
    begin
        src_d = SRC_INTERNAL;
        if (scs_q == SCS_SECONDARY)
            src_d = SRC_SECONDARY;
        else if (scs_q == SCS_CONFIG && state_q == ST_EXTERNAL)
            src_d = SRC_EXTERNAL;
        else if (scs_q == SCS_CONFIG && state_q == ST_SETTLE && !two_speed)
            src_d = SRC_EXTERNAL;
    end

    // registered so the mux control never glitches
    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            clk_src_o <= SRC_INTERNAL;
            internal_freq_select_o <= IFS_RESET;
            osc_fail_irq_o <= 1'b0;
        end
        else
        begin
            clk_src_o <= src_d;
            internal_freq_select_o <= ifs_q;
            osc_fail_irq_o <= osc_fail_flag_q && osc_fail_ie_q;
        end
    end

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    logic [7:0] rd_d;

    always_comb
    begin
        rd_d = 8'h00;
        unique case (reg_addr_i)
            ADDR_OSC_CONTROL:
            begin
                rd_d[IFS_MSB:IFS_LSB] = ifs_q;
                rd_d[SCS_MSB:SCS_LSB] = scs_q;
            end
            ADDR_OSC_STATUS:
            begin
                rd_d[EXT_CLOCK_RUNNING_FLAG_BIT] = ext_running;
                rd_d[FAIL_STATE_BIT] = (state_q == ST_FAILED);
            end
            ADDR_FLAGS_TWO:
                rd_d[OSC_FAIL_FLAG_BIT] = osc_fail_flag_q;
            ADDR_INT_EN_TWO:
                rd_d[OSC_FAIL_IE_BIT] = osc_fail_ie_q;
        endcase
    end

    // read data stand one cycle after the strobe, zero otherwise
    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            reg_rdata_o <= 8'h00;
        else if (reg_rd_i)
            reg_rdata_o <= rd_d;
        else
            reg_rdata_o <= 8'h00;
    end
endmodule : fail_safe_clock_monitor
`default_nettype wire

// File: logic/level_sync.sv
// two flip-flop synchroniser for one level
`timescale 1ns/1ps
`default_nettype none
module level_sync (
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic async_i,
    output logic sync_o
);
    logic meta_q;

    // first stage feeds only the second stage
    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            meta_q <= 1'b0;
            sync_o <= 1'b0;
        end
        else
        begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end
endmodule : level_sync
`default_nettype wire
